// >>> gpio_pkg.sv
/*
 * package for the general digital i/o port: register offsets, reset
 * values, field positions and sleep mode encodings.
 * assumes a 32-bit apb bus with word-aligned registers.
 */
package gpio_pkg;

  localparam int unsigned port_width = 8;

  // register byte offsets on apb
  localparam logic [7:0] off_output = 8'h00;
  localparam logic [7:0] off_direction = 8'h04;
  localparam logic [7:0] off_input = 8'h08;
  localparam logic [7:0] off_special = 8'h0c;
  localparam logic [7:0] off_irq_enable = 8'h10;
  localparam logic [7:0] off_irq_status = 8'h14;
  localparam logic [7:0] off_irq_clear = 8'h18;
  localparam logic [7:0] off_sleep = 8'h1c;

  // field positions
  localparam int unsigned pud_bit = 2;

  // reset values
  localparam logic [7:0] output_reset = 8'h00;
  localparam logic [7:0] direction_reset = 8'h00;
  localparam logic [7:0] special_reset = 8'h00;
  localparam logic [7:0] irq_enable_reset = 8'h00;
  localparam logic [2:0] sleep_reset = 3'h0;

  // sleep controller modes
  typedef enum logic [2:0] {
    sleep_idle = 3'h0,
    sleep_adc_noise = 3'h1,
    sleep_power_down = 3'h2,
    sleep_power_save = 3'h3,
    sleep_standby = 3'h6,
    sleep_ext_standby = 3'h7
  } sleep_mode_t;

endpackage : gpio_pkg

// >>> gpio_port.sv
/*
 * general digital i/o port: eight pins with direction, output/pull-up
 * and synchronised input bits, a global pull-up disable, a sleep input
 * clamp with interrupt and alternate-function overrides, and a wake-up
 * any-change flag. registers sit on apb with a level interrupt.
 * assumes pad buffers outside resolve drive, pull-up and pad level.
 */
// Operation
// - a set direction bit makes the pin an output, clear makes input
// - pull-up on for input pin with output bit one, global disable off
// - pull-up off when output bit is zero or pin is output
// - reset tri-states every pin at once, no clock needed
// - output pin drives the level of its output bit
// - global pull-up disable turns off all pull-ups
// - input bit reads the synchronised pin level in any direction
// - latch open while clock high, then flop on rising edge
// - external edge reaches input bit in half to one and half periods
// - written pin value seen in input bit two periods after write
// - deep sleep modes clamp the digital input to ground
// - enabled external interrupt pins are not clamped
// - alternate functions may override the sleep clamp
// - high any-change pin with interrupt disabled flags on wake
// - input register read-only; output and direction read-write
`timescale 1ns/1ps
module gpio_port
  import gpio_pkg::*;
#(
  parameter int unsigned width = gpio_pkg::port_width
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [width-1:0] pad_in,
  output logic [width-1:0] pad_out,
  output logic [width-1:0] pad_oe,
  output logic [width-1:0] pad_pullup,
  input wire logic [width-1:0] ext_irq_enable,
  input wire logic [width-1:0] any_change_pin,
  input wire logic [width-1:0] alt_clamp_override,
  output logic irq
);

  import gpio_pkg::*;

  // register storage, one bit per pin except special function and sleep mode
  logic [width-1:0] output_register_q;
  logic [width-1:0] direction_register_q;
  logic [7:0] special_function_register_q;
  logic [width-1:0] irq_enable_q;
  logic [width-1:0] irq_status_q;
  logic [2:0] sleep_mode_q;
  logic [width-1:0] input_register;
  logic [width-1:0] drive_en;
  logic [width-1:0] drive_val;
  logic [width-1:0] pullup_en;
  logic [width-1:0] pad_clamped;
  logic [width-1:0] wake_set;
  logic [width-1:0] irq_clear;
  logic [width-1:0] pad_meta_q;
  logic [width-1:0] pad_level_q;
  logic clamp_active;
  logic clamp_was_q;
  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  logic mapped;

  // decode mapped offsets
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      off_output, off_direction, off_input, off_special,
      off_irq_enable, off_irq_status, off_irq_clear, off_sleep:
        is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // clamping sleep modes
  function automatic logic is_deep_sleep(input logic [2:0] m);
    case (m)
      sleep_power_down, sleep_power_save,
      sleep_standby, sleep_ext_standby: is_deep_sleep = 1'b1;
      default: is_deep_sleep = 1'b0;
    endcase
  endfunction : is_deep_sleep

  assign addr = paddr[7:0];
  assign mapped = is_mapped(addr) && (paddr[31:8] == 24'h000000);
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_en = psel && !penable && !pwrite;

  assign clamp_active = is_deep_sleep(sleep_mode_q);

  // pin decode and clamp
  pin_ctrl #(.width(width)) u_ctrl (
    .dir(direction_register_q),
    .out_val(output_register_q),
    .pullup_global_disable(special_function_register_q[pud_bit]),
    .clamp_active(clamp_active),
    .clamp_override(ext_irq_enable | alt_clamp_override),
    .pad_raw(pad_in),
    .drive_en(drive_en),
    .drive_val(drive_val),
    .pullup_en(pullup_en),
    .pad_clamped(pad_clamped)
  );

  pin_sync #(.width(width)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pad_in(pad_clamped),
    .synced(input_register)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_oe <= '0;
      pad_out <= '0;
      pad_pullup <= '0;
    end else begin
      pad_oe <= drive_en;
      pad_out <= drive_val;
      pad_pullup <= pullup_en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_register_q <= output_reset;
      direction_register_q <= direction_reset;
      special_function_register_q <= special_reset;
      irq_enable_q <= irq_enable_reset;
      sleep_mode_q <= sleep_reset;
    end else if (wr_en) begin
      case (addr)
        off_output: output_register_q <= pwdata[width-1:0];
        off_direction: direction_register_q <= pwdata[width-1:0];
        off_special: special_function_register_q <= pwdata[7:0];
        off_irq_enable: irq_enable_q <= pwdata[width-1:0];
        off_sleep: sleep_mode_q <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // raw pad level kept unclamped for the wake check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_meta_q <= '0;
      pad_level_q <= '0;
    end else begin
      pad_meta_q <= pad_in;
      pad_level_q <= pad_meta_q;
    end
  end

  // remembers the clamp to spot the wake edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clamp_was_q <= 1'b0;
    end else begin
      clamp_was_q <= clamp_active;
    end
  end

  // the released clamp reads as a change
  assign wake_set = (clamp_was_q && !clamp_active) ?
    (any_change_pin & ~ext_irq_enable & ~alt_clamp_override & pad_level_q)
    : '0;
  assign irq_clear = (wr_en && addr == off_irq_clear) ?
    pwdata[width-1:0] : '0;

  // sticky status, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clear) | wake_set;
    end
  end

  // level interrupt from enabled status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_status_q & ~irq_clear) | wake_set) & irq_enable_q);
    end
  end

  // read data registered in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en && !mapped) begin
      // unmapped reads return zero, upper address bits included
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= 32'h00000000;
      case (addr)
        off_output: prdata[width-1:0] <= output_register_q;
        off_direction: prdata[width-1:0] <= direction_register_q;
        off_input: prdata[width-1:0] <= input_register;
        off_special: prdata[7:0] <= special_function_register_q;
        off_irq_enable: prdata[width-1:0] <= irq_enable_q;
        off_irq_status: prdata[width-1:0] <= irq_status_q;
        off_sleep: prdata[2:0] <= sleep_mode_q;
        default: ;
      endcase
    end
  end

  // one-wait-free answer; error on unmapped access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

endmodule : gpio_port

// >>> gpio_port_sva.sv
/* checker for the port's apb handshake and pad outputs.
   assumes one clock pclk and async active-low presetn. */
`timescale 1ns/1ps
module gpio_port_sva
  import gpio_pkg::*;
#(
  parameter int unsigned width = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [width-1:0] pad_out,
  input wire logic [width-1:0] pad_oe,
  input wire logic [width-1:0] pad_pullup
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // setup phase and a completed write to one word
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr(logic [7:0] a);
    psel && penable && pready && pwrite && paddr == {24'h0, a};
  endsequence
  property p_answer; s_setup |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_unmap;
    s_setup ##0 (paddr > {24'h0, off_sleep} || paddr[1:0] != 2'h0)
      |=> pslverr;
  endproperty
  property p_dir;
    s_wr(off_direction) |-> ##2 pad_oe == $past(pwdata[7:0], 2);
  endproperty
  property p_out;
    s_wr(off_output) |-> ##2 pad_out == ($past(pwdata[7:0], 2) & pad_oe);
  endproperty
  property p_undriven; ~|(pad_out & ~pad_oe); endproperty
  property p_pullup; ~|(pad_pullup & pad_oe); endproperty
  // reset must act with no clock help, so it is never disabled
  property p_reset;
    disable iff (1'b0) !presetn |-> ~|pad_oe && ~|pad_pullup;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  a_one: assert property (p_one) else $error("pready too long");
  a_unmap: assert property (p_unmap) else $error("no error");
  a_dir: assert property (p_dir) else $error("bad oe");
  a_out: assert property (p_out) else $error("bad out");
  a_undriven: assert property (p_undriven) else $error("input drives");
  a_pullup: assert property (p_pullup) else $error("pullup on out");
  a_reset: assert property (p_reset) else $error("pin not tristate");
endmodule : gpio_port_sva

// >>> pad_model.sv
/* pad model for the port: external circuitry on the eight pads.
   assumes pad_oe high means the port drives the pad. */
`timescale 1ns/1ps
module pad_model (
  input wire logic pclk,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup,
  input wire logic [7:0] ext_drive,
  input wire logic [7:0] ext_level,
  output logic [7:0] pad_in
);
  logic [7:0] float_q = 8'h00;
  // a floating pad wanders, so a stale level is never trusted
  always @(posedge pclk) float_q <= ~float_q;
  // port driver wins, then the outside source, then the pull-up
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drive & ext_level)
    | (~pad_oe & ~ext_drive & (pad_pullup | float_q));
endmodule : pad_model

// >>> pin_ctrl.sv
/*
 * per-pin driver and pull-up decode, plus the sleep input clamp.
 * purely combinational; assumes register bits come from flops.
 */
`timescale 1ns/1ps
module pin_ctrl #(
  parameter int unsigned width = 8
) (
  input wire logic [width-1:0] dir,
  input wire logic [width-1:0] out_val,
  input wire logic pullup_global_disable,
  input wire logic clamp_active,
  input wire logic [width-1:0] clamp_override,
  input wire logic [width-1:0] pad_raw,
  output logic [width-1:0] drive_en,
  output logic [width-1:0] drive_val,
  output logic [width-1:0] pullup_en,
  output logic [width-1:0] pad_clamped
);

  assign drive_en = dir;
  assign drive_val = out_val & dir;
  assign pullup_en = ~dir & out_val & {width{~pullup_global_disable}};
  assign pad_clamped = pad_raw & ~({width{clamp_active}} & ~clamp_override);

endmodule : pin_ctrl

// >>> pin_sync.sv
/*
 * input synchroniser: a latch open while the clock is high, then a flop
 * on the next rising edge. assumes the pad level is already clamped.
 */
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned width = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [width-1:0] pad_in,
  output logic [width-1:0] synced
);

  logic [width-1:0] latch_q;

  // transparent latch stage
  // non-blocking so the flop below still sees the level held while low
  always_latch begin
    if (!presetn) begin
      latch_q <= '0;
    end else if (pclk) begin
      latch_q <= pad_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synced <= '0;
    end else begin
      synced <= latch_q;
    end
  end

endmodule : pin_sync

// >>> tb_gpio_port.sv
/* bench for gpio_port: apb registers, pads, sleep clamp and wake irq.
   assumes pad_model on the pads and the bound checker. */
`timescale 1ns/1ps
module tb_gpio_port;
  import gpio_pkg::*;
  logic pclk = 1'b0;
  logic presetn;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, er;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [7:0] pad_in, pad_out, pad_oe, pad_pullup, dir, ov, pe, km, ex;
  logic [7:0] eie = 8'h00, acp = 8'h00, alt = 8'h00, exd = 8'h00;
  logic [7:0] exl = 8'h00;
  logic pullup_global_disable;
  int failures = 0, checks_done = 0;
  gpio_port gpio_port_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .ext_irq_enable(eie), .any_change_pin(acp), .alt_clamp_override(alt),
    .irq(irq));
  pad_model pad_model_i (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .ext_drive(exd), .ext_level(exl),
    .pad_in(pad_in));
  // 100 mhz clock
  initial forever #5 pclk = ~pclk;
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // one transfer; request held until pready is seen, then an idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready and read data are taken at one and the same rising edge
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        failures++;
        print_verdict();
      end
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr
  initial begin
    logic [2:0] m;
    presetn <= 1'b0;
    void'($urandom(39));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, off_direction, 32'h0);
    chk("dir", rd, 32'h0);
    $display("reset test done");
    // random modes; one register per write keeps the in-between states
    for (int i = 0; i < 40; i++) begin
      dir = 8'($urandom);
      ov = 8'($urandom);
      pullup_global_disable = 1'($urandom);
      exd <= 8'($urandom);
      exl <= 8'($urandom);
      wr(off_output, ov);
      wr(off_direction, dir);
      wr(off_special, {5'h0, pullup_global_disable, 2'h0});
      wr(off_input, ~ov);
      pe = ~dir & ov & {8{~pullup_global_disable}};
      @(negedge pclk);
      chk("oe", 32'(pad_oe), 32'(dir));
      chk("out", 32'(pad_out), 32'(dir & ov));
      chk("pullup", 32'(pad_pullup), 32'(pe));
      @(posedge pclk);
      apb(1'b0, off_output, 32'h0);
      chk("out reg", rd, 32'(ov));
      km = dir | exd | pe;
      ex = (dir & ov) | (~dir & exd & exl) | (pe & ~exd);
      apb(1'b0, off_input, 32'h0);
      // idle edges pass before the read-back
      chk("in", rd & 32'(km), 32'(ex));
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("err", {31'h0, er}, 32'h1);
    chk("err rd", rd, 32'h0);
    $display("random test done");
    // reset while driving drops the pins before any clock
    wr(off_direction, 8'hff);
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    chk("async", 32'(pad_oe), 32'h0);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    $display("async reset test done");
    // pads high; bit 1 irq enabled, bit 2 alternate, bit 0 any-change
    exd <= 8'hff;
    exl <= 8'hff;
    eie <= 8'h02;
    alt <= 8'h04;
    acp <= 8'h01;
    for (int k = 0; k < 8; k++) begin
      if (k == 4 || k == 5) continue;
      m = 3'(k);
      wr(off_irq_enable, {7'h0, m[0]});
      wr(off_sleep, {5'h0, m});
      repeat (3) @(posedge pclk);
      apb(1'b0, off_input, 32'h0);
      // clamping modes are exactly those with bit 1 set
      chk("clamp", rd, m[1] ? 32'h6 : 32'hff);
      wr(off_sleep, 8'h00);
      repeat (3) @(posedge pclk);
      apb(1'b0, off_irq_status, 32'h0);
      chk("wake", rd, {31'h0, m[1]});
      chk("irq", {31'h0, irq}, {31'h0, m[1] & m[0]});
      wr(off_irq_clear, 8'h01);
      @(negedge pclk);
      chk("irq clr", {31'h0, irq}, 32'h0);
      @(posedge pclk);
    end
    $display("sleep test done");
    print_verdict();
  end
endmodule : tb_gpio_port
bind gpio_port gpio_port_sva #(.width(width)) sva_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup));
